// File: include/lrca_defs.svh
// Constants for the local/remote control access selector.
// Assumes inclusion by its bare name from the package and design files.
`ifndef LRCA_DEFS_SVH
`define LRCA_DEFS_SVH

// Register offsets (index on the plain register port)
`define LRCA_ADDR_W 4
`define LRCA_OFS_CONFIG 4'h0
`define LRCA_OFS_RESERVE 4'h1
`define LRCA_OFS_STATUS 4'h2
`define LRCA_OFS_ACCESS 4'h3

// Config field positions
`define LRCA_CFG_AUTH_LSB 0
`define LRCA_CFG_SRC_BIT 2

// Reset values: authority local/remote, source front-panel button
`define LRCA_CFG_RESET 32'h0000_0000

// Status field positions
`define LRCA_ST_CODE_LSB 0
`define LRCA_ST_MLEV_BIT 4
`define LRCA_ST_MODE_LSB 8

// State codes published to display and network
`define LRCA_CODE_OFF 3'h0
`define LRCA_CODE_LOCAL 3'h1
`define LRCA_CODE_REMOTE 3'h2
`define LRCA_CODE_STATION 3'h3
`define LRCA_CODE_MULTI 3'h4

// Originator categories carried by a network command
`define LRCA_ORIG_STATION 2'h1
`define LRCA_ORIG_REMOTE 2'h2

`endif

// File: include/lrca_pkg.sv
// Types for the local/remote control access selector.
// Assumes lrca_defs.svh is on the include path.
`include "lrca_defs.svh"

package lrca_pkg;

   typedef enum logic [2:0] {
      LRCA_MODE_OFF,
      LRCA_MODE_LOCAL,
      LRCA_MODE_STATION,
      LRCA_MODE_REMOTE,
      LRCA_MODE_ALL
   } lrca_mode_t;

   typedef enum logic [1:0] {
      LRCA_AUTH_LR,
      LRCA_AUTH_LR_COMB,
      LRCA_AUTH_LSR,
      LRCA_AUTH_LS_COMB
   } lrca_auth_t;

endpackage

// File: design/lrca_prio.sv
// Fixed-priority resolver of the five mode-request inputs.
// Assumes inputs are already synchronised to sys_clk_in.
`timescale 1ns/1ps

module lrca_prio
   import lrca_pkg::*;
(
   input wire logic [4:0] request_in,
   output lrca_mode_t mode_out
);

   // Bit order: 0 off, 1 local, 2 station, 3 remote, 4 all
   always_comb begin
      if (request_in[0]) begin
         mode_out = LRCA_MODE_OFF;
      end else if (request_in[1]) begin
         mode_out = LRCA_MODE_LOCAL;
      end else if (request_in[2]) begin
         mode_out = LRCA_MODE_STATION;
      end else if (request_in[3]) begin
         mode_out = LRCA_MODE_REMOTE;
      end else if (request_in[4]) begin
         mode_out = LRCA_MODE_ALL;
      end else begin
         mode_out = LRCA_MODE_OFF;
      end
   end

endmodule

// File: design/lrca_sync.sv
// Two-flop synchroniser for a vector of independent pin levels.
// Assumes each bit is a slow level; bits are not sampled coherently.
`timescale 1ns/1ps

module lrca_sync #(
   parameter int WIDTH = 8
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
      end else begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
      end
   end

   assign sync_out = stage2_reg;

endmodule

// File: design/lrca_top.sv
// Local/remote control access selector: access state, authority, grants.
// Assumes panel pins are asynchronous; register port and network command
// strobes are synchronous to sys_clk_in.
//
// Added by the designer: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "lrca_defs.svh"

module lrca_top
   import lrca_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   // Front-panel button: 0 off, 1 local, 2 remote, 3 local+remote
   input wire logic [1:0] panel_button_in,
   // Mode requests: 0 off, 1 local, 2 station, 3 remote, 4 all
   input wire logic [4:0] mode_request_in,
   // Reservation value recovered from nonvolatile storage
   input wire logic nv_reservation_in,
   input wire logic nv_valid_in,
   // Network command check, one cycle strobe
   input wire logic cmd_valid_in,
   input wire logic [1:0] cmd_category_in,
   input wire logic cmd_iec_in,
   // Register port
   input wire logic [`LRCA_ADDR_W-1:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   output logic [31:0] reg_rdata_out,
   // State outputs, one-hot
   output logic state_off_out,
   output logic state_local_out,
   output logic state_station_out,
   output logic state_remote_out,
   output logic state_all_out,
   output logic [2:0] access_state_code_out,
   output logic multilevel_status_flag_out,
   output logic local_grant_out,
   output logic remote_grant_out,
   output logic station_grant_out,
   output logic cmd_accept_out,
   output logic cmd_reject_out,
   output logic nv_write_out,
   output logic nv_data_out
);

   ////////////////////////////////////////////////////////////////////////
   // Synchronisers and priority resolution

   logic [7:0] pins_sync;
   lrca_mode_t req_mode;

   lrca_sync #(
      .WIDTH(8)
   ) u_sync (
      .sys_clk_in(sys_clk_in),
      .rst_n_in(rst_n_in),
      .async_in({panel_button_in, mode_request_in, nv_reservation_in}),
      .sync_out(pins_sync)
   );

   lrca_prio u_prio (
      .request_in(pins_sync[5:1]),
      .mode_out(req_mode)
   );

   ////////////////////////////////////////////////////////////////////////
   // Configuration and reservation registers

   lrca_auth_t auth_reg, auth_next;
   logic source_reg, source_next;
   logic reserve_reg, reserve_next;
   logic nv_loaded_reg, nv_loaded_next;
   logic nv_write_reg, nv_write_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [1:0] prime_reg, prime_next;
   logic [4:0] onehot_reg, onehot_next;
   logic [2:0] code_reg, code_next;
   logic mlev_reg, mlev_next;
   logic local_reg, local_next;
   logic remote_reg, remote_next;
   logic station_reg, station_next;

   // Remote network access is possible in every level with a remote form
   function automatic logic remote_allowed(input lrca_auth_t a,
                                           input lrca_mode_t m);
      remote_allowed = (m == LRCA_MODE_REMOTE) ||
                       (m == LRCA_MODE_ALL && a != LRCA_AUTH_LR) ||
                       (m == LRCA_MODE_STATION && a != LRCA_AUTH_LR);
   endfunction

   lrca_mode_t mode_now;
   logic res_write;

   always_comb begin
      if (source_reg) begin
         mode_now = req_mode;
      end else begin
         unique case (pins_sync[7:6])
            2'h1: mode_now = LRCA_MODE_LOCAL;
            2'h2: mode_now = LRCA_MODE_REMOTE;
            2'h3: mode_now = LRCA_MODE_ALL;
            default: mode_now = LRCA_MODE_OFF;
         endcase
      end
   end

   assign res_write = reg_write_in && reg_addr_in == `LRCA_OFS_RESERVE &&
                      reg_wdata_in[1:0] == `LRCA_ORIG_STATION &&
                      remote_allowed(auth_reg, mode_now);

   always_comb begin
      auth_next = auth_reg;
      source_next = source_reg;
      reserve_next = reserve_reg;
      // Synchroniser holds its reset zero for two edges; restore after it
      prime_next = {prime_reg[0], 1'b1};
      nv_loaded_next = nv_loaded_reg || (nv_valid_in && prime_reg[1]);
      nv_write_next = 1'b0;
      if (reg_write_in && reg_addr_in == `LRCA_OFS_CONFIG) begin
         auth_next = lrca_auth_t'(reg_wdata_in[`LRCA_CFG_AUTH_LSB +: 2]);
         source_next = reg_wdata_in[`LRCA_CFG_SRC_BIT];
      end
      // restore after reset, store on accepted write
      if (!nv_loaded_reg && nv_valid_in && prime_reg[1]) begin
         reserve_next = pins_sync[0];
      end else if (res_write) begin
         reserve_next = reg_wdata_in[4];
         nv_write_next = 1'b1;
      end
      rdata_next = 32'h0000_0000;
      if (reg_read_in) begin
         unique case (reg_addr_in)
            `LRCA_OFS_CONFIG: begin
               rdata_next[`LRCA_CFG_AUTH_LSB +: 2] = auth_reg;
               rdata_next[`LRCA_CFG_SRC_BIT] = source_reg;
            end
            `LRCA_OFS_RESERVE: rdata_next[4] = reserve_reg;
            `LRCA_OFS_STATUS: begin
               rdata_next[`LRCA_ST_CODE_LSB +: 3] = code_reg;
               rdata_next[`LRCA_ST_MLEV_BIT] = mlev_reg;
               rdata_next[`LRCA_ST_MODE_LSB +: 3] = mode_now;
            end
            `LRCA_OFS_ACCESS:
               rdata_next[2:0] = {station_reg, remote_reg, local_reg};
            default: rdata_next = 32'h0000_0000;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Access decision

   always_comb begin
      onehot_next = 5'h00;
      onehot_next[mode_now] = 1'b1;
      code_next = `LRCA_CODE_OFF;
      mlev_next = 1'b0;
      local_next = 1'b0;
      remote_next = 1'b0;
      station_next = 1'b0;
      unique case (auth_reg)
         LRCA_AUTH_LR: begin
            if (mode_now == LRCA_MODE_LOCAL) begin
               code_next = `LRCA_CODE_LOCAL;
               local_next = 1'b1;
            end else if (mode_now == LRCA_MODE_REMOTE) begin
               code_next = `LRCA_CODE_REMOTE;
               remote_next = 1'b1;
            end
         end
         LRCA_AUTH_LR_COMB: begin
            if (mode_now == LRCA_MODE_LOCAL) begin
               code_next = `LRCA_CODE_LOCAL;
               local_next = 1'b1;
            end else if (mode_now == LRCA_MODE_REMOTE) begin
               code_next = `LRCA_CODE_REMOTE;
               remote_next = 1'b1;
            end else if (mode_now == LRCA_MODE_ALL) begin
               code_next = `LRCA_CODE_MULTI;
               mlev_next = 1'b1;
               local_next = 1'b1;
               remote_next = 1'b1;
            end
         end
         LRCA_AUTH_LSR: begin
            if (mode_now == LRCA_MODE_LOCAL) begin
               code_next = `LRCA_CODE_LOCAL;
               local_next = 1'b1;
            end else if (mode_now == LRCA_MODE_STATION ||
                         (mode_now == LRCA_MODE_REMOTE && reserve_reg)) begin
               code_next = `LRCA_CODE_STATION;
               station_next = 1'b1;
            end else if (mode_now == LRCA_MODE_REMOTE) begin
               code_next = `LRCA_CODE_REMOTE;
               remote_next = 1'b1;
            end
         end
         LRCA_AUTH_LS_COMB: begin
            if (mode_now == LRCA_MODE_LOCAL) begin
               code_next = `LRCA_CODE_LOCAL;
               local_next = 1'b1;
            end else if (mode_now == LRCA_MODE_STATION ||
                         (mode_now == LRCA_MODE_REMOTE && reserve_reg)) begin
               code_next = `LRCA_CODE_STATION;
               station_next = 1'b1;
            end else if (mode_now == LRCA_MODE_REMOTE) begin
               code_next = `LRCA_CODE_REMOTE;
               remote_next = 1'b1;
            end else if (mode_now == LRCA_MODE_ALL) begin
               code_next = `LRCA_CODE_MULTI;
               mlev_next = 1'b1;
               local_next = 1'b1;
               station_next = 1'b1;
               remote_next = 1'b1;
            end
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Network command check

   logic acc_reg, acc_next;
   logic rej_reg, rej_next;
   logic cat_ok;

   always_comb begin
      cat_ok = 1'b0;
      if (auth_reg == LRCA_AUTH_LR || auth_reg == LRCA_AUTH_LR_COMB) begin
         cat_ok = remote_reg;
      end else if (cmd_category_in == `LRCA_ORIG_STATION) begin
         // station level only for IEC 61850 clients
         cat_ok = station_reg && cmd_iec_in;
      end else if (cmd_category_in == `LRCA_ORIG_REMOTE) begin
         cat_ok = remote_reg;
      end
      acc_next = cmd_valid_in && cat_ok;
      rej_next = cmd_valid_in && !cat_ok;
   end

   ////////////////////////////////////////////////////////////////////////
   // State registers

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         auth_reg <= LRCA_AUTH_LR;
         source_reg <= 1'b0;
         reserve_reg <= 1'b0;
         nv_loaded_reg <= 1'b0;
         prime_reg <= 2'h0;
         nv_write_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         onehot_reg <= 5'h01;
         code_reg <= `LRCA_CODE_OFF;
         mlev_reg <= 1'b0;
         local_reg <= 1'b0;
         remote_reg <= 1'b0;
         station_reg <= 1'b0;
         acc_reg <= 1'b0;
         rej_reg <= 1'b0;
      end else begin
         auth_reg <= auth_next;
         source_reg <= source_next;
         reserve_reg <= reserve_next;
         nv_loaded_reg <= nv_loaded_next;
         prime_reg <= prime_next;
         nv_write_reg <= nv_write_next;
         rdata_reg <= rdata_next;
         onehot_reg <= onehot_next;
         code_reg <= code_next;
         mlev_reg <= mlev_next;
         local_reg <= local_next;
         remote_reg <= remote_next;
         station_reg <= station_next;
         acc_reg <= acc_next;
         rej_reg <= rej_next;
      end
   end

   assign reg_rdata_out = rdata_reg;
   assign state_off_out = onehot_reg[0];
   assign state_local_out = onehot_reg[1];
   assign state_station_out = onehot_reg[2];
   assign state_remote_out = onehot_reg[3];
   assign state_all_out = onehot_reg[4];
   assign access_state_code_out = code_reg;
   assign multilevel_status_flag_out = mlev_reg;
   assign local_grant_out = local_reg;
   assign remote_grant_out = remote_reg;
   assign station_grant_out = station_reg;
   assign cmd_accept_out = acc_reg;
   assign cmd_reject_out = rej_reg;
   assign nv_write_out = nv_write_reg;
   assign nv_data_out = reserve_reg;

endmodule

// File: tb/lrca_chk.sv
// Port-level checker for the access selector.
// Assumes one clock domain and binding to lrca_top.
`timescale 1ns/1ps
`include "lrca_defs.svh"

module lrca_chk (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire logic [`LRCA_ADDR_W-1:0] reg_addr_in,
   input wire logic [31:0] reg_wdata_in,
   input wire logic reg_write_in,
   input wire logic reg_read_in,
   input wire logic [31:0] reg_rdata_out,
   input wire logic cmd_valid_in,
   input wire logic [1:0] cmd_category_in,
   input wire logic state_off_out,
   input wire logic state_local_out,
   input wire logic state_station_out,
   input wire logic state_remote_out,
   input wire logic state_all_out,
   input wire logic [2:0] access_state_code_out,
   input wire logic multilevel_status_flag_out,
   input wire logic local_grant_out,
   input wire logic remote_grant_out,
   input wire logic station_grant_out,
   input wire logic cmd_accept_out,
   input wire logic cmd_reject_out,
   input wire logic nv_write_out
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!rst_n_in);

   a_state_one_hot:
      assert property ($onehot({state_off_out, state_local_out,
         state_station_out, state_remote_out, state_all_out}))
      else $error("state outputs not one-hot");
   a_off_no_grant:
      assert property (state_off_out |-> access_state_code_out == 3'h0
         && !local_grant_out && !remote_grant_out)
      else $error("off state with code or grant");
   a_local_code:
      assert property (state_local_out |-> access_state_code_out == 3'h1
         && local_grant_out && !remote_grant_out)
      else $error("local state code or grant wrong");
   a_multi_code:
      assert property (multilevel_status_flag_out |->
         access_state_code_out == 3'h4 && local_grant_out)
      else $error("multilevel flag without code 4");
   a_cmd_answer:
      assert property (cmd_valid_in |=> cmd_accept_out != cmd_reject_out)
      else $error("command not answered once");
   a_cmd_quiet:
      assert property (!cmd_valid_in |=> !cmd_accept_out && !cmd_reject_out)
      else $error("command answer without command");
   a_remote_accept:
      assert property (cmd_valid_in && remote_grant_out &&
         cmd_category_in == `LRCA_ORIG_REMOTE |=> cmd_accept_out)
      else $error("remote command refused");
   a_no_grant_reject:
      assert property (cmd_valid_in && !remote_grant_out &&
         !station_grant_out |=> cmd_reject_out)
      else $error("command accepted without grant");
   a_reserve_guard:
      assert property (!(reg_write_in && reg_addr_in == `LRCA_OFS_RESERVE &&
         reg_wdata_in[1:0] == `LRCA_ORIG_STATION) |=> !nv_write_out)
      else $error("reservation stored without station write");
   a_rdata_idle:
      assert property (!reg_read_in |=> reg_rdata_out == 32'h0)
      else $error("read data outside read slot");
endmodule

bind lrca_top lrca_chk chk_u (.sys_clk_in, .rst_n_in, .reg_addr_in,
   .reg_wdata_in, .reg_write_in, .reg_read_in, .reg_rdata_out, .cmd_valid_in,
   .cmd_category_in, .state_off_out, .state_local_out, .state_station_out,
   .state_remote_out, .state_all_out, .access_state_code_out,
   .multilevel_status_flag_out, .local_grant_out, .remote_grant_out,
   .station_grant_out, .cmd_accept_out, .cmd_reject_out, .nv_write_out);

// File: tb/lrca_net_model.sv
// Network client and nonvolatile store beside the access selector.
// Assumes commands are issued through the send task.
`timescale 1ns/1ps

module lrca_net_model (
   input wire logic sys_clk_in,
   input wire logic nv_write_in,
   input wire logic nv_data_in,
   output logic nv_reservation_out,
   output logic nv_valid_out,
   output logic cmd_valid_out,
   output logic [1:0] cmd_category_out,
   output logic cmd_iec_out
);
   logic stored;

   initial stored = 1'b0;
   always @(posedge sys_clk_in) begin
      if (nv_write_in) begin
         stored <= nv_data_in;
      end
   end
   assign nv_reservation_out = stored;
   assign nv_valid_out = 1'b1;

   initial begin
      cmd_valid_out = 1'b0;
      cmd_category_out = 2'h3;
      cmd_iec_out = 1'b0;
   end

   task automatic send(input logic [1:0] c, input logic i);
      @(posedge sys_clk_in);
      cmd_valid_out <= 1'b1;
      cmd_category_out <= c;
      cmd_iec_out <= i;
      @(posedge sys_clk_in);
      // Released lines toggle so no stale value is trusted
      cmd_valid_out <= 1'b0;
      cmd_category_out <= ~c;
      cmd_iec_out <= ~i;
      #1;
   endtask
endmodule

// File: tb/tb_local_remote_control_access.sv
// Testbench for the access selector: register port, pins, commands.
// Assumes the network model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "lrca_defs.svh"

module tb_local_remote_control_access;
   logic sys_clk_in, rst_n_in, reg_write_in, reg_read_in;
   logic [1:0] panel_button_in, cmd_category_in;
   logic [4:0] mode_request_in;
   logic [3:0] reg_addr_in;
   logic [31:0] reg_wdata_in, reg_rdata_out;
   logic nv_reservation_in, nv_valid_in, cmd_valid_in, cmd_iec_in;
   logic state_off_out, state_local_out, state_station_out;
   logic state_remote_out, state_all_out, multilevel_status_flag_out;
   logic local_grant_out, remote_grant_out, station_grant_out;
   logic cmd_accept_out, cmd_reject_out, nv_write_out, nv_data_out;
   logic [2:0] access_state_code_out;
   int n_fail = 0;
   int compares = 0;
   logic [4:0] rq[9] = '{5'h00, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1E, 5'h1C,
      5'h18, 5'h03};
   logic [31:0] st[9] = '{32'h000, 32'h101, 32'h200, 32'h302, 32'h400,
      32'h101, 32'h200, 32'h302, 32'h000};
   logic [31:0] ac[9] = '{32'h0, 32'h1, 32'h0, 32'h2, 32'h0, 32'h1, 32'h0,
      32'h2, 32'h0};

   lrca_top dut_u (.sys_clk_in, .rst_n_in, .panel_button_in,
      .mode_request_in, .nv_reservation_in, .nv_valid_in, .cmd_valid_in,
      .cmd_category_in, .cmd_iec_in, .reg_addr_in, .reg_wdata_in,
      .reg_write_in, .reg_read_in, .reg_rdata_out, .state_off_out,
      .state_local_out, .state_station_out, .state_remote_out,
      .state_all_out, .access_state_code_out, .multilevel_status_flag_out,
      .local_grant_out, .remote_grant_out, .station_grant_out,
      .cmd_accept_out, .cmd_reject_out, .nv_write_out, .nv_data_out);

   lrca_net_model net_u (.sys_clk_in, .nv_write_in(nv_write_out),
      .nv_data_in(nv_data_out), .nv_reservation_out(nv_reservation_in),
      .nv_valid_out(nv_valid_in), .cmd_valid_out(cmd_valid_in),
      .cmd_category_out(cmd_category_in), .cmd_iec_out(cmd_iec_in));

   initial begin
      sys_clk_in = 1'b0;
      forever #2.5 sys_clk_in = ~sys_clk_in;
   end

   task automatic cmp(input logic [31:0] got, exp, input string what);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("wrong value at %0t: %s got %h", $time, what, got);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      reg_write_in <= 1'b1;
      reg_addr_in <= a;
      reg_wdata_in <= d;
      @(posedge sys_clk_in);
      reg_write_in <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
   endtask

   task automatic rd(input logic [3:0] a, input logic [31:0] e, string w);
      @(posedge sys_clk_in);
      reg_read_in <= 1'b1;
      reg_addr_in <= a;
      @(posedge sys_clk_in);
      reg_read_in <= 1'b0;
      #1 cmp(reg_rdata_out, e, w);
   endtask

   // Pins pass a two-flop synchroniser, so allow margin before reading
   task automatic pins(input logic [1:0] b, input logic [4:0] r);
      @(posedge sys_clk_in);
      panel_button_in <= b;
      mode_request_in <= r;
      repeat (5) @(posedge sys_clk_in);
   endtask

   task automatic cmd(input logic [1:0] c, input logic i, e, string w);
      net_u.send(c, i);
      cmp({30'h0, cmd_accept_out, cmd_reject_out}, {30'h0, e, !e}, w);
   endtask

   task automatic pulse_reset;
      @(posedge sys_clk_in);
      rst_n_in <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
   endtask

   task automatic give_verdict;
      $display("compares %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      #20000;
      n_fail++;
      $display("wrong value at %0t: run hung", $time);
      give_verdict();
   end

   initial begin
      rst_n_in = 1'b0;
      {reg_write_in, reg_read_in, reg_addr_in, reg_wdata_in} = '0;
      panel_button_in = 2'h0;
      mode_request_in = 5'h00;
      repeat (3) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      rd(`LRCA_OFS_CONFIG, 32'h0, "config reset");
      rd(4'hF, 32'h0, "unmapped read");
      rd(`LRCA_OFS_STATUS, 32'h0, "off status");
      $display("test reset done");
      pins(2'h1, 5'h08);
      rd(`LRCA_OFS_STATUS, 32'h101, "button local");
      rd(`LRCA_OFS_ACCESS, 32'h1, "button local access");
      pins(2'h2, 5'h08);
      rd(`LRCA_OFS_STATUS, 32'h302, "button remote");
      $display("test button done");
      wr(`LRCA_OFS_CONFIG, 32'h4);
      for (int k = 0; k < 9; k++) begin
         pins(2'h1, rq[k]);
         rd(`LRCA_OFS_STATUS, st[k], "input status");
         cmp({27'h0, state_all_out, state_remote_out, state_station_out,
            state_local_out, state_off_out}, 32'h1 << st[k][10:8],
            "state outputs");
         rd(`LRCA_OFS_ACCESS, ac[k], "input access");
      end
      pins(2'h1, 5'h08);
      cmd(2'h1, 1'b0, 1'b1, "station as remote");
      cmd(2'h0, 1'b0, 1'b1, "no category check");
      pins(2'h1, 5'h02);
      cmd(2'h2, 1'b1, 1'b0, "local refuses net");
      $display("test inputs done");
      wr(`LRCA_OFS_CONFIG, 32'h5);
      pins(2'h1, 5'h10);
      rd(`LRCA_OFS_STATUS, 32'h414, "combined all");
      rd(`LRCA_OFS_ACCESS, 32'h3, "combined grants");
      wr(`LRCA_OFS_CONFIG, 32'h1);
      pins(2'h3, 5'h00);
      rd(`LRCA_OFS_STATUS, 32'h414, "button both");
      $display("test multilevel done");
      wr(`LRCA_OFS_CONFIG, 32'h6);
      pins(2'h1, 5'h08);
      wr(`LRCA_OFS_RESERVE, 32'h12);
      rd(`LRCA_OFS_STATUS, 32'h302, "remote category refused");
      wr(`LRCA_OFS_RESERVE, 32'h11);
      cmp({31'h0, net_u.stored}, 32'h1, "reservation stored");
      rd(`LRCA_OFS_STATUS, 32'h303, "station reserved");
      rd(`LRCA_OFS_ACCESS, 32'h4, "station grant");
      cmd(2'h1, 1'b1, 1'b1, "station over iec");
      cmd(2'h1, 1'b0, 1'b0, "station other protocol");
      cmd(2'h2, 1'b1, 1'b0, "remote while reserved");
      wr(`LRCA_OFS_CONFIG, 32'h7);
      pins(2'h1, 5'h10);
      rd(`LRCA_OFS_STATUS, 32'h414, "station combined all");
      rd(`LRCA_OFS_ACCESS, 32'h7, "station combined grants");
      wr(`LRCA_OFS_CONFIG, 32'h6);
      pins(2'h1, 5'h08);
      $display("test station done");
      pulse_reset();
      wr(`LRCA_OFS_CONFIG, 32'h6);
      pins(2'h1, 5'h08);
      rd(`LRCA_OFS_STATUS, 32'h303, "reservation restored");
      wr(`LRCA_OFS_CONFIG, 32'h4);
      rd(`LRCA_OFS_STATUS, 32'h302, "reservation ignored");
      $display("test persistence done");
      give_verdict();
   end
endmodule
